// [rtl/tcc_regs.svh]
/*
  Register map, field positions, reset values and timing counts of the
  16-bit timer counter core with input capture.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// byte offsets
`define TCC_OFS_CTRL_A    6'h00
`define TCC_OFS_CTRL_B    6'h04
`define TCC_OFS_CNT_LO    6'h08
`define TCC_OFS_CNT_HI    6'h0C
`define TCC_OFS_CAP_LO    6'h10
`define TCC_OFS_CAP_HI    6'h14
`define TCC_OFS_CMPA_LO   6'h18
`define TCC_OFS_CMPA_HI   6'h1C
`define TCC_OFS_FLAGS     6'h20
`define TCC_OFS_IRQ_EN    6'h24
`define TCC_OFS_CMP_CS    6'h28

////////////////////////////////////////////////////////////////////////////
// field positions
`define TCC_B_FILT_EN     7
`define TCC_B_EDGE_SEL    6
`define TCC_B_WGM_HI      4
`define TCC_B_WGM_LO      3
`define TCC_B_CS_HI       2
`define TCC_F_OVF         0
`define TCC_F_CAP         5
`define TCC_CS_CMP_SEL    2

////////////////////////////////////////////////////////////////////////////
// writable masks and reset values
`define TCC_CTRLA_MASK    8'h03
`define TCC_CTRLB_MASK    8'hDF
`define TCC_FLAG_MASK     8'h21
`define TCC_RST_BYTE      8'h00
`define TCC_RST_WORD      16'h0000

////////////////////////////////////////////////////////////////////////////
// count limits and timing
`define TCC_BOTTOM        16'h0000
`define TCC_MAX           16'hFFFF
`define TCC_TOP_8BIT      16'h00FF
`define TCC_TOP_9BIT      16'h01FF
`define TCC_TOP_10BIT     16'h03FF
`define TCC_FILT_SAMPLES  4

`endif

// [rtl/tcc_pkg.sv]
/*
  Types shared by the timer counter core: bus request carrier,
  waveform modes and bus handshake states.
  Assumes tcc_regs.svh supplies the numeric constants.
*/
package tcc_pkg;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } tcc_avs_req_s;

  typedef enum logic [3:0] {
    TCC_M_NORMAL = 4'h0, TCC_M_PC8   = 4'h1, TCC_M_PC9   = 4'h2,
    TCC_M_PC10   = 4'h3, TCC_M_CTC_A = 4'h4, TCC_M_FP8   = 4'h5,
    TCC_M_FP9    = 4'h6, TCC_M_FP10  = 4'h7, TCC_M_PFC_I = 4'h8,
    TCC_M_PFC_A  = 4'h9, TCC_M_PC_I  = 4'hA, TCC_M_PC_A  = 4'hB,
    TCC_M_CTC_I  = 4'hC, TCC_M_RSVD  = 4'hD, TCC_M_FP_I  = 4'hE,
    TCC_M_FP_A   = 4'hF
  } tcc_mode_e;

  typedef enum logic {
    TCC_BUS_WAIT = 1'b0,
    TCC_BUS_DONE = 1'b1
  } tcc_bus_e;

endpackage

// [rtl/tcc_timer.sv]
/*
  Counter core and input capture unit of a 16-bit timer counter,
  reached over an Avalon-MM slave port with waitrequest.
  Assumes one 25 MHz clock; pins arrive asynchronously; the interrupt
  controller pulses an acknowledge when it executes a request.
*/
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_timer
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // register bus
  input  wire tcc_pkg::tcc_avs_req_s avs_req_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // event inputs
  input  wire logic                 external_tick_pin_i,
  input  wire logic                 capture_pin_i,
  input  wire logic                 comparator_output_i,
  // interrupt handshake
  input  wire logic                 capture_irq_ack_i,
  input  wire logic                 overflow_irq_ack_i,
  output logic                      capture_irq_o,
  output logic                      overflow_irq_o,
  // count indications
  output logic                      count_top_o,
  output logic                      count_bottom_o
);

  ////////////////////////////////////////////////////////////////////////
  // mode decoding
  function automatic logic is_updown(input logic [3:0] m);
    is_updown = (m == tcc_pkg::TCC_M_PC8)   || (m == tcc_pkg::TCC_M_PC9)
             || (m == tcc_pkg::TCC_M_PC10)  || (m == tcc_pkg::TCC_M_PFC_I)
             || (m == tcc_pkg::TCC_M_PFC_A) || (m == tcc_pkg::TCC_M_PC_I)
             || (m == tcc_pkg::TCC_M_PC_A);
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == tcc_pkg::TCC_M_PFC_I) || (m == tcc_pkg::TCC_M_PC_I)
              || (m == tcc_pkg::TCC_M_CTC_I) || (m == tcc_pkg::TCC_M_FP_I);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m,
                                         input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    if (m == tcc_pkg::TCC_M_PC8 || m == tcc_pkg::TCC_M_FP8)
      top_of = `TCC_TOP_8BIT;
    else if (m == tcc_pkg::TCC_M_PC9 || m == tcc_pkg::TCC_M_FP9)
      top_of = `TCC_TOP_9BIT;
    else if (m == tcc_pkg::TCC_M_PC10 || m == tcc_pkg::TCC_M_FP10)
      top_of = `TCC_TOP_10BIT;
    else if (cap_is_top(m))
      top_of = cap;
    else if (m == tcc_pkg::TCC_M_CTC_A || m == tcc_pkg::TCC_M_PFC_A
          || m == tcc_pkg::TCC_M_PC_A || m == tcc_pkg::TCC_M_FP_A)
      top_of = cmpa;
    else
      top_of = `TCC_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctrl_a_ff;
  logic [7:0]  ctrl_b_ff;
  logic [7:0]  hold_ff;
  logic [15:0] count_value_ff;
  logic [15:0] capture_value_ff;
  logic [15:0] compare_a_ff;
  logic        overflow_flag_ff;
  logic        capture_flag_ff;
  logic        ovf_irq_en_ff;
  logic        capture_irq_enable_ff;
  logic        comparator_capture_select_ff;
  logic        dir_up_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [9:0]  pre_ff;
  logic [2:0]  s1_ff;
  logic [2:0]  s2_ff;
  logic [2:0]  s3_ff;
  logic [2:0]  lvl_ff;
  logic        ext_prev_ff;
  logic [`TCC_FILT_SAMPLES-2:0] filt_sh_ff;
  logic        filt_ff;
  logic        det_prev_ff;
  logic        irq_cap_ff;
  logic        irq_ovf_ff;
  logic        top_ff;
  logic        bottom_ff;

  logic [3:0]  waveform_mode_select;
  logic [15:0] top_val;
  logic        accept;
  logic        wr_done;
  logic [7:0]  wbyte;
  logic [5:0]  addr;
  logic [7:0]  nxt_rbyte;
  logic        timer_tick;
  logic [15:0] nxt_count;
  logic        nxt_dir_up;
  logic        ovf_evt;
  logic        cap_src;
  logic        det_in;
  logic        cap_trig;

  assign waveform_mode_select =
    {ctrl_b_ff[`TCC_B_WGM_HI:`TCC_B_WGM_LO], ctrl_a_ff[1:0]};
  assign top_val = top_of(waveform_mode_select, compare_a_ff,
                          capture_value_ff);
  assign addr    = avs_req_i.address;
  assign wbyte   = avs_req_i.writedata[7:0];
  assign accept  = (avs_req_i.read | avs_req_i.write) & wait_ff;
  assign wr_done = ~wait_ff & avs_req_i.write & avs_req_i.byteenable[0];

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: wait one cycle, answer, then wait again
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wait_ff <= 1'b1;
    else
      wait_ff <= ~accept;
  end

  always_comb
  begin
    nxt_rbyte = `TCC_RST_BYTE;
    if (addr == `TCC_OFS_CTRL_A)
      nxt_rbyte = ctrl_a_ff;
    else if (addr == `TCC_OFS_CTRL_B)
      nxt_rbyte = ctrl_b_ff;
    else if (addr == `TCC_OFS_CNT_LO)
      nxt_rbyte = count_value_ff[7:0];
    else if (addr == `TCC_OFS_CNT_HI || addr == `TCC_OFS_CAP_HI)
      nxt_rbyte = hold_ff;
    else if (addr == `TCC_OFS_CAP_LO)
      nxt_rbyte = capture_value_ff[7:0];
    else if (addr == `TCC_OFS_CMPA_LO)
      nxt_rbyte = compare_a_ff[7:0];
    else if (addr == `TCC_OFS_CMPA_HI)
      nxt_rbyte = compare_a_ff[15:8];
    else if (addr == `TCC_OFS_FLAGS)
    begin
      nxt_rbyte[`TCC_F_OVF] = overflow_flag_ff;
      nxt_rbyte[`TCC_F_CAP] = capture_flag_ff;
    end
    else if (addr == `TCC_OFS_IRQ_EN)
    begin
      nxt_rbyte[`TCC_F_OVF] = ovf_irq_en_ff;
      nxt_rbyte[`TCC_F_CAP] = capture_irq_enable_ff;
    end
    else if (addr == `TCC_OFS_CMP_CS)
      nxt_rbyte[`TCC_CS_CMP_SEL] = comparator_capture_select_ff;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_ff <= 32'h00000000;
    else if (accept && avs_req_i.read)
      rdata_ff <= {24'h000000, nxt_rbyte};
  end

  ////////////////////////////////////////////////////////////////////////
  // holding register: upper byte of every 16-bit access except compare A reads
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hold_ff <= `TCC_RST_BYTE;
    else if (accept && avs_req_i.read && addr == `TCC_OFS_CNT_LO)
      hold_ff <= count_value_ff[15:8];
    else if (accept && avs_req_i.read && addr == `TCC_OFS_CAP_LO)
      hold_ff <= capture_value_ff[15:8];
    else if (wr_done && (addr == `TCC_OFS_CNT_HI
          || addr == `TCC_OFS_CAP_HI || addr == `TCC_OFS_CMPA_HI))
      hold_ff <= wbyte;
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_a_ff                    <= `TCC_RST_BYTE;
      ctrl_b_ff                    <= `TCC_RST_BYTE;
      ovf_irq_en_ff                <= 1'b0;
      capture_irq_enable_ff        <= 1'b0;
      comparator_capture_select_ff <= 1'b0;
    end
    else if (wr_done)
    begin
      if (addr == `TCC_OFS_CTRL_A)
        ctrl_a_ff <= wbyte & `TCC_CTRLA_MASK;
      else if (addr == `TCC_OFS_CTRL_B)
        ctrl_b_ff <= wbyte & `TCC_CTRLB_MASK;
      else if (addr == `TCC_OFS_IRQ_EN)
      begin
        ovf_irq_en_ff         <= wbyte[`TCC_F_OVF];
        capture_irq_enable_ff <= wbyte[`TCC_F_CAP];
      end
      else if (addr == `TCC_OFS_CMP_CS)
        comparator_capture_select_ff <= wbyte[`TCC_CS_CMP_SEL];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      compare_a_ff <= `TCC_RST_WORD;
    else if (wr_done && addr == `TCC_OFS_CMPA_LO)
      compare_a_ff <= {hold_ff, wbyte};
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: tick pin, capture pin, comparator
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_ff  <= 3'h0;
      s2_ff  <= 3'h0;
      s3_ff  <= 3'h0;
      lvl_ff <= 3'h0;
    end
    else
    begin
      s1_ff <= {comparator_output_i, capture_pin_i,
                external_tick_pin_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 3; i++)
        if (s2_ff[i] == s3_ff[i])
          lvl_ff[i] <= s3_ff[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock select: prescaler enables or tick pin edges
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_ff      <= 10'h000;
      ext_prev_ff <= 1'b0;
    end
    else
    begin
      pre_ff      <= pre_ff + 10'h001;
      ext_prev_ff <= lvl_ff[0];
    end
  end

  always_comb
  begin
    case (ctrl_b_ff[`TCC_B_CS_HI:0])
      3'h1:    timer_tick = 1'b1;
      3'h2:    timer_tick = &pre_ff[2:0];
      3'h3:    timer_tick = &pre_ff[5:0];
      3'h4:    timer_tick = &pre_ff[7:0];
      3'h5:    timer_tick = &pre_ff;
      3'h6:    timer_tick = ext_prev_ff & ~lvl_ff[0];
      3'h7:    timer_tick = ~ext_prev_ff & lvl_ff[0];
      default: timer_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // counter sequence
  always_comb
  begin
    nxt_count  = count_value_ff + 16'h0001;
    nxt_dir_up = dir_up_ff;
    ovf_evt    = 1'b0;
    if (is_updown(waveform_mode_select))
    begin
      if (dir_up_ff && count_value_ff >= top_val)
      begin
        nxt_dir_up = 1'b0;
        nxt_count  = count_value_ff - 16'h0001;
      end
      else if (!dir_up_ff && count_value_ff == `TCC_BOTTOM)
      begin
        nxt_dir_up = 1'b1;
        ovf_evt    = 1'b1;
      end
      else if (!dir_up_ff)
        nxt_count = count_value_ff - 16'h0001;
    end
    else if (count_value_ff == top_val)
    begin
      nxt_count  = `TCC_BOTTOM;
      nxt_dir_up = 1'b1;
      ovf_evt    = (top_val == `TCC_MAX)
                || (waveform_mode_select[2] & waveform_mode_select[0])
                || (waveform_mode_select[2] & waveform_mode_select[1]
                    & ~cap_is_top(waveform_mode_select)
                    ? 1'b1 : (waveform_mode_select == tcc_pkg::TCC_M_FP_I));
    end
    else if (count_value_ff == `TCC_MAX)
      ovf_evt = 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_value_ff <= `TCC_RST_WORD;
      dir_up_ff      <= 1'b1;
    end
    else if (wr_done && addr == `TCC_OFS_CNT_LO)
      count_value_ff <= {hold_ff, wbyte};
    else if (timer_tick)
    begin
      count_value_ff <= nxt_count;
      dir_up_ff      <= nxt_dir_up;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      top_ff    <= 1'b0;
      bottom_ff <= 1'b0;
    end
    else
    begin
      top_ff    <= (count_value_ff == top_val);
      bottom_ff <= (count_value_ff == `TCC_BOTTOM);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture source, noise filter, edge detector
  assign cap_src = comparator_capture_select_ff ? lvl_ff[2]
                                                : lvl_ff[1];

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      filt_sh_ff <= '0;
      filt_ff    <= 1'b0;
    end
    else
    begin
      // three stored samples plus the live one: four cycles, not five
      filt_sh_ff <= {filt_sh_ff[`TCC_FILT_SAMPLES-3:0], cap_src};
      if (&{filt_sh_ff, cap_src} || ~|{filt_sh_ff, cap_src})
        filt_ff <= cap_src;
    end
  end

  assign det_in = ctrl_b_ff[`TCC_B_FILT_EN] ? filt_ff : cap_src;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      det_prev_ff <= 1'b0;
    else
      det_prev_ff <= det_in;
  end

  assign cap_trig = ~cap_is_top(waveform_mode_select)
                  & (ctrl_b_ff[`TCC_B_EDGE_SEL]
                     ? (det_in & ~det_prev_ff)
                     : (~det_in & det_prev_ff));

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      capture_value_ff <= `TCC_RST_WORD;
    else if (cap_trig)
      capture_value_ff <= count_value_ff;
    else if (wr_done && addr == `TCC_OFS_CAP_LO
             && cap_is_top(waveform_mode_select))
      capture_value_ff <= {hold_ff, wbyte};
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags: hardware set beats clear
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      overflow_flag_ff <= 1'b0;
      capture_flag_ff  <= 1'b0;
    end
    else
    begin
      if (cap_trig)
        capture_flag_ff <= 1'b1;
      else if (capture_irq_ack_i || (wr_done && addr == `TCC_OFS_FLAGS
               && wbyte[`TCC_F_CAP]))
        capture_flag_ff <= 1'b0;
      if (timer_tick && ovf_evt && !(wr_done && addr == `TCC_OFS_CNT_LO))
        overflow_flag_ff <= 1'b1;
      else if (overflow_irq_ack_i || (wr_done && addr == `TCC_OFS_FLAGS
               && wbyte[`TCC_F_OVF]))
        overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_cap_ff <= 1'b0;
      irq_ovf_ff <= 1'b0;
    end
    else
    begin
      irq_cap_ff <= capture_flag_ff & capture_irq_enable_ff;
      irq_ovf_ff <= overflow_flag_ff & ovf_irq_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign capture_irq_o     = irq_cap_ff;
  assign overflow_irq_o    = irq_ovf_ff;
  assign count_top_o       = top_ff;
  assign count_bottom_o    = bottom_ff;

endmodule

// [verification/tcc_timer_checker.sv]
/* checker of bus handshake and interrupt clearing of tcc_timer.
   bound to the core by the bench top; sees core ports only. */
`timescale 1ns/1ps
module tcc_timer_checker
(
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  // register bus
  input wire tcc_pkg::tcc_avs_req_s avs_req_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  // events and interrupts
  input wire logic                  capture_pin_i,
  input wire logic                  comparator_output_i,
  input wire logic                  capture_irq_ack_i,
  input wire logic                  overflow_irq_ack_i,
  input wire logic                  capture_irq_o,
  input wire logic                  overflow_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  logic       req;
  logic       cap_ff;
  logic       cmp_ff;
  logic [4:0] quiet_ff;

  assign req = avs_req_i.read | avs_req_i.write;

  ////////////////////////////////////////////////////////////////////////
  // cycles since the last pin change or bus write
  always_ff @(posedge clk_i)
  begin
    cap_ff <= capture_pin_i;
    cmp_ff <= comparator_output_i;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      quiet_ff <= 5'h00;
    else if (capture_pin_i != cap_ff || comparator_output_i != cmp_ff
             || avs_req_i.write)
      quiet_ff <= 5'h00;
    else if (quiet_ff != 5'h1F)
      quiet_ff <= quiet_ff + 5'h01;

  ////////////////////////////////////////////////////////////////////////
  sequence s_accept;
    req && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_one_wait: assert property (s_accept |=> s_answer)
    else $error("waitrequest not low for exactly one cycle");
  a_no_idle_answer: assert property (!req && avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("answer without request");
  a_wait_low_once: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("waitrequest low twice");
  a_rdata_upper: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  a_rdata_hold: assert property (!(avs_req_i.read && avs_waitrequest_o)
    |=> $stable(avs_readdata_o)) else $error("read data changed");
  a_cap_ack_clears: assert property (capture_irq_ack_i |->
    ##2 !capture_irq_o) else $error("capture ack did not clear");
  a_ovf_ack_clears: assert property (overflow_irq_ack_i |->
    ##2 !overflow_irq_o) else $error("overflow ack did not clear");
  a_capirq_cause: assert property ($rose(capture_irq_o) |->
    quiet_ff < 5'h14) else $error("capture interrupt without event");
endmodule

// [verification/tcc_event_model.sv]
/* far side model: capture pin, comparator output and tick pin.
   capture and comparator levels requested by the bench, launched after a clock edge; tick pin tied low. */
`timescale 1ns/1ps
module tcc_event_model
(
  // clock
  input  wire logic clk_i,
  // requested levels
  input  wire logic cap_lvl_i,
  input  wire logic cmp_lvl_i,
  // pins toward the core
  output logic      capture_pin_o,
  output logic      comparator_output_o,
  output logic      external_tick_pin_o
);
  // pins settle on the first clock edge, well inside reset
  always @(posedge clk_i)
  begin
    capture_pin_o       <= cap_lvl_i;
    comparator_output_o <= cmp_lvl_i;
  end
  // no external tick source in use
  assign external_tick_pin_o = 1'b0;
endmodule

// [verification/tb_timer16_counter_input_capture.sv]
/* bench top for tcc_timer: register accesses and pin events.
   assumes tcc_event_model drives the pins; checker bound below. */
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tb_timer16_counter_input_capture;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  tcc_pkg::tcc_avs_req_s req = '0;
  logic [31:0]           rdata;
  logic                  waitreq;
  logic                  cap_lvl = 1'b0;
  logic                  cmp_lvl = 1'b0;
  logic                  cap_ack = 1'b0;
  logic                  ovf_ack = 1'b0;
  logic                  cap_pin;
  logic                  cmp_out;
  logic                  tick_pin;
  wire  [3:0]            watch;
  logic [7:0]            q;
  int                    num_errors = 0;
  int                    checked = 0;
  int                    n0;
  int                    n1;

  always #20 clk = ~clk;

  tcc_event_model i_evt (.clk_i(clk), .cap_lvl_i(cap_lvl),
    .cmp_lvl_i(cmp_lvl), .capture_pin_o(cap_pin),
    .comparator_output_o(cmp_out), .external_tick_pin_o(tick_pin));
  tcc_timer i_dut (.clk_i(clk), .resetn_i(resetn), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .external_tick_pin_i(tick_pin), .capture_pin_i(cap_pin),
    .comparator_output_i(cmp_out), .capture_irq_ack_i(cap_ack),
    .overflow_irq_ack_i(ovf_ack), .capture_irq_o(watch[2]),
    .overflow_irq_o(watch[3]), .count_top_o(watch[1]),
    .count_bottom_o(watch[0]));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // one bus cycle, entered just after a clock edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    req.address <= a;
    req.read <= !w;
    req.write <= w;
    req.writedata <= {24'h000000, d};
    req.byteenable <= 4'hF;
    @(posedge clk);
    while (waitreq !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 50)
      begin
        num_errors++;
        final_report;
      end
    end
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask

  task automatic wait_bit(input int b, output int n);
    n = 0;
    while (watch[b] !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 2000)
      begin
        num_errors++;
        final_report;
      end
    end
  endtask

  task automatic ack(input logic c);
    cap_ack <= c;
    ovf_ack <= !c;
    @(posedge clk);
    cap_ack <= 1'b0;
    ovf_ack <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rc(`TCC_OFS_CTRL_B, 8'h00);
    rc(`TCC_OFS_FLAGS, 8'h00);
    wr(6'h3C, 8'hAA);
    rc(6'h3C, 8'h00);
    wr(`TCC_OFS_CNT_HI, 8'h12);
    wr(`TCC_OFS_CNT_LO, 8'h34);
    wr(`TCC_OFS_CMPA_LO, 8'h56);
    repeat (30) @(posedge clk);
    rc(`TCC_OFS_CNT_LO, 8'h34);
    rc(`TCC_OFS_CNT_HI, 8'h12);
    rc(`TCC_OFS_CMPA_HI, 8'h12);
    wr(`TCC_OFS_CAP_HI, 8'h77);
    wr(`TCC_OFS_CAP_LO, 8'h88);
    rc(`TCC_OFS_CAP_LO, 8'h00);
    $display("test access done");
    wr(`TCC_OFS_CNT_HI, 8'h00);
    wr(`TCC_OFS_CTRL_B, 8'h01);
    wr(`TCC_OFS_CNT_LO, 8'h10);
    wr(`TCC_OFS_CTRL_B, 8'h00);
    bus(1'b0, `TCC_OFS_CNT_LO, 8'h00);
    chk(16'(q > 8'h10 && q < 8'h30), 16'h0001);
    rc(`TCC_OFS_CNT_HI, 8'h00);
    wr(`TCC_OFS_CMPA_HI, 8'h00);
    wr(`TCC_OFS_CMPA_LO, 8'h05);
    wr(`TCC_OFS_CNT_LO, 8'h00);
    wr(`TCC_OFS_CTRL_B, 8'h09);
    wait_bit(1, n0);
    wait_bit(0, n0);
    repeat (40) @(posedge clk);
    wr(`TCC_OFS_CTRL_B, 8'h08);
    bus(1'b0, `TCC_OFS_CNT_LO, 8'h00);
    chk(16'(q <= 8'h05), 16'h0001);
    $display("test count done");
    wr(`TCC_OFS_CNT_HI, 8'hFF);
    wr(`TCC_OFS_CNT_LO, 8'hFD);
    wr(`TCC_OFS_IRQ_EN, 8'h21);
    wr(`TCC_OFS_CTRL_B, 8'h01);
    wait_bit(3, n0);
    wr(`TCC_OFS_CTRL_B, 8'h00);
    rc(`TCC_OFS_FLAGS, 8'h01);
    ack(1'b0);
    rc(`TCC_OFS_FLAGS, 8'h00);
    bus(1'b0, `TCC_OFS_CNT_LO, 8'h00);
    rc(`TCC_OFS_CNT_HI, 8'h00);
    $display("test overflow done");
    wr(`TCC_OFS_CNT_HI, 8'h0A);
    wr(`TCC_OFS_CNT_LO, 8'hBC);
    wr(`TCC_OFS_CTRL_B, 8'h40);
    cap_lvl <= 1'b1;
    wait_bit(2, n0);
    rc(`TCC_OFS_CAP_LO, 8'hBC);
    rc(`TCC_OFS_CAP_HI, 8'h0A);
    rc(`TCC_OFS_FLAGS, 8'h20);
    wr(`TCC_OFS_CNT_HI, 8'h0D);
    wr(`TCC_OFS_CNT_LO, 8'hEF);
    wr(`TCC_OFS_CTRL_B, 8'h00);
    cap_lvl <= 1'b0;
    repeat (20) @(posedge clk);
    rc(`TCC_OFS_CAP_LO, 8'hEF);
    rc(`TCC_OFS_CAP_HI, 8'h0D);
    ack(1'b1);
    rc(`TCC_OFS_FLAGS, 8'h00);
    cap_lvl <= 1'b1;
    repeat (20) @(posedge clk);
    rc(`TCC_OFS_FLAGS, 8'h00);
    $display("test capture done");
    wr(`TCC_OFS_CTRL_B, 8'h80);
    cap_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    cap_lvl <= 1'b1;
    repeat (12) @(posedge clk);
    rc(`TCC_OFS_FLAGS, 8'h00);
    cap_lvl <= 1'b0;
    wait_bit(2, n1);
    chk(16'(n1 - n0), 16'h0004);
    wr(`TCC_OFS_FLAGS, 8'h20);
    rc(`TCC_OFS_FLAGS, 8'h00);
    $display("test filter done");
    wr(`TCC_OFS_CTRL_B, 8'h40);
    wr(`TCC_OFS_CMP_CS, 8'h04);
    wr(`TCC_OFS_FLAGS, 8'h20);
    cap_lvl <= 1'b1;
    repeat (20) @(posedge clk);
    rc(`TCC_OFS_FLAGS, 8'h00);
    cmp_lvl <= 1'b1;
    wait_bit(2, n0);
    wr(`TCC_OFS_FLAGS, 8'h20);
    wr(`TCC_OFS_CMP_CS, 8'h00);
    wr(`TCC_OFS_CTRL_B, 8'h18);
    wr(`TCC_OFS_FLAGS, 8'h20);
    wr(`TCC_OFS_CAP_HI, 8'h00);
    wr(`TCC_OFS_CAP_LO, 8'h20);
    rc(`TCC_OFS_CAP_LO, 8'h20);
    cap_lvl <= 1'b0;
    repeat (20) @(posedge clk);
    rc(`TCC_OFS_FLAGS, 8'h00);
    rc(`TCC_OFS_CAP_LO, 8'h20);
    $display("test source done");
    final_report;
  end
endmodule

bind tcc_timer tcc_timer_checker i_chk (.clk_i(clk_i),
  .resetn_i(resetn_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .capture_pin_i(capture_pin_i), .comparator_output_i(comparator_output_i),
  .capture_irq_ack_i(capture_irq_ack_i),
  .overflow_irq_ack_i(overflow_irq_ack_i),
  .capture_irq_o(capture_irq_o), .overflow_irq_o(overflow_irq_o));
